// ===== rtl/mie_exec.sv
// Purpose: execution tail of an 8-bit core: subtracts, skips, sets, swaps, table reads, xor
// Assumes: data memory and program memory answer a read strobe one cycle later
// Notes: every instruction runs issue, fetch, exec; a taken skip adds one dummy cycle
//
// How it works
// - rotate right through carry into acc: old carry to bit 7, bit 0 to carry
// - subtract with borrow: acc + ~m + carry, four flags, to acc or memory
// - decrement memory; when zero, drop prefetched instruction and add dummy cycle
// - decrement into acc, memory untouched, skip with dummy cycle when zero
// - byte set writes all ones, no flag changes
// - bit set forces only the selected bit to one
// - increment memory; when it wraps to zero, skip with dummy cycle
// - increment into acc, memory untouched, skip with dummy cycle when zero
// - skip with dummy cycle when the selected bit is one
// - subtract memory: acc + ~m + 1, four flags, to acc or memory
// - subtract immediate: acc + ~imm + 1 into acc, four flags
// - nibble exchange in place, no flags
// - nibble exchange into acc, memory and flags untouched
// - skip with dummy cycle when the whole operand is zero
// - copy operand into acc, skip with dummy cycle when it is zero
// - skip with dummy cycle when the selected bit is zero
// - current page table read: low byte to memory, high part to table high
// - last page table read: low byte to memory, high part to table high
// - xor with memory or immediate into acc, only zero flag changes
// - xor written back to memory, zero flag updated
`default_nettype none

module mie_exec
  import mie_pkg::*;
(
  // clock, reset, enable
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic ce,
  // register port
  input wire logic [RAW-1:0] reg_addr,
  input wire logic [DW-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [DW-1:0] reg_rdata,
  // instruction issue
  input wire logic issue_valid,
  input wire mie_req_t issue_req,
  output logic exec_busy,
  output logic exec_done,
  output logic skip_next,
  // data memory
  output mie_dmem_t dmem_req,
  input wire logic [DW-1:0] dmem_rdata,
  // program memory
  output mie_pmem_t pmem_req,
  input wire logic [PW-1:0] pmem_rdata
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    mie_state_t state;
    mie_req_t req;
    logic [DW-1:0] acc;
    mie_flags_t flags;
    logic [DW-1:0] table_pointer;
    logic [6:0] table_high;
    logic [3:0] code_page;
    mie_dmem_t dmem;
    mie_pmem_t pmem;
    logic [DW-1:0] rdata;
    logic busy;
    logic done;
    logic skip;
  } mie_st_t;

  mie_st_t st_r;
  mie_st_t st_nxt;

  // ----------------------------------------------------------------
  // datapath
  // ----------------------------------------------------------------
  logic imm_op;
  logic borrow_op;
  logic cin;
  logic [DW-1:0] opnd;
  logic [DW-1:0] sub_b;
  logic [4:0] sum_lo;
  logic [7:0] sum_l7;
  logic [8:0] sum_full;
  mie_flags_t sub_flags;
  logic [DW-1:0] dec_val;
  logic [DW-1:0] inc_val;
  logic [DW-1:0] swp_val;
  logic [DW-1:0] xor_val;
  logic [DW-1:0] bit_mask;
  logic sel_bit;
  logic skip_cond;
  logic skip_op;

  assign imm_op = (st_r.req.op == OP_SUBTRACT_IMMEDIATE) ||
                  (st_r.req.op == OP_EXCLUSIVE_OR_IMMEDIATE);
  assign borrow_op = (st_r.req.op == OP_SUBTRACT_WITH_BORROW) ||
                     (st_r.req.op == OP_SUBTRACT_BORROW_TO_MEMORY);
  // borrow forms feed the carry, the others a constant one
  assign cin = borrow_op ? st_r.flags.carry : 1'b1;
  assign opnd = imm_op ? st_r.req.imm : dmem_rdata;
  assign sub_b = ~opnd;
  assign sum_lo = 5'({1'b0, st_r.acc[3:0]}) + 5'({1'b0, sub_b[3:0]}) + 5'(cin);
  assign sum_l7 = 8'({1'b0, st_r.acc[6:0]}) + 8'({1'b0, sub_b[6:0]}) + 8'(cin);
  assign sum_full = 9'({1'b0, st_r.acc}) + 9'({1'b0, sub_b}) + 9'(cin);
  // overflow is carry into bit 7 against carry out of it
  assign sub_flags.signed_range = sum_l7[7] ^ sum_full[8];
  assign sub_flags.zero = (sum_full[7:0] == 8'h00);
  assign sub_flags.half_carry = sum_lo[4];
  assign sub_flags.carry = sum_full[8];
  assign dec_val = dmem_rdata - 8'h01;
  assign inc_val = dmem_rdata + 8'h01;
  assign swp_val = {dmem_rdata[3:0], dmem_rdata[7:4]};
  assign xor_val = st_r.acc ^ opnd;
  assign bit_mask = 8'h01 << st_r.req.bit_sel;
  assign sel_bit = dmem_rdata[st_r.req.bit_sel];

  always_comb begin
    skip_op = 1'b1;
    case (st_r.req.op)
      OP_DECREMENT_SKIP_IF_ZERO, OP_DECREMENT_TO_ACC_SKIP_IF_ZERO: begin
        skip_cond = (dec_val == 8'h00);
      end
      OP_INCREMENT_SKIP_IF_ZERO, OP_INCREMENT_TO_ACC_SKIP_IF_ZERO: begin
        skip_cond = (inc_val == 8'h00);
      end
      OP_SKIP_IF_BIT_SET: begin
        skip_cond = sel_bit;
      end
      OP_SKIP_IF_BIT_CLEAR: begin
        skip_cond = !sel_bit;
      end
      OP_SKIP_IF_ZERO, OP_MOVE_AND_SKIP_IF_ZERO: begin
        skip_cond = (dmem_rdata == 8'h00);
      end
      default: begin
        skip_cond = 1'b0;
        skip_op = 1'b0;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    st_nxt = st_r;
    st_nxt.dmem.rd = 1'b0;
    st_nxt.dmem.wr = 1'b0;
    st_nxt.pmem.rd = 1'b0;
    st_nxt.done = 1'b0;
    st_nxt.skip = 1'b0;
    st_nxt.rdata = 8'h00;

    // register port; execution results below take priority
    if (reg_wr) begin
      if (reg_addr == REG_ACC) begin
        st_nxt.acc = reg_wdata;
      end else if (reg_addr == REG_STATUS) begin
        st_nxt.flags = mie_flags_t'(reg_wdata[3:0]);
      end else if (reg_addr == REG_TABLE_POINTER) begin
        st_nxt.table_pointer = reg_wdata;
      end else if (reg_addr == REG_CODE_PAGE) begin
        st_nxt.code_page = reg_wdata[3:0];
      end
    end
    if (reg_rd) begin
      if (reg_addr == REG_ACC) begin
        st_nxt.rdata = st_r.acc;
      end else if (reg_addr == REG_STATUS) begin
        st_nxt.rdata = {4'h0, st_r.flags};
      end else if (reg_addr == REG_TABLE_POINTER) begin
        st_nxt.rdata = st_r.table_pointer;
      end else if (reg_addr == REG_TABLE_HIGH) begin
        st_nxt.rdata = {1'b0, st_r.table_high};
      end else if (reg_addr == REG_CODE_PAGE) begin
        st_nxt.rdata = {4'h0, st_r.code_page};
      end else if (reg_addr == REG_EXEC_STATE) begin
        st_nxt.rdata = 8'(st_r.busy) << BUSY_POS;
      end
    end

    case (st_r.state)
      S_IDLE: begin
        if (issue_valid) begin
          st_nxt.req = issue_req;
          st_nxt.dmem.rd = 1'b1;
          st_nxt.dmem.addr = issue_req.addr;
          if (issue_req.op == OP_TABLE_READ_CURRENT_PAGE) begin
            st_nxt.pmem.rd = 1'b1;
            st_nxt.pmem.addr = {st_r.code_page, st_r.table_pointer};
          end else if (issue_req.op == OP_TABLE_READ_LAST_PAGE) begin
            st_nxt.pmem.rd = 1'b1;
            st_nxt.pmem.addr = {LAST_PAGE, st_r.table_pointer};
          end
          st_nxt.state = S_FETCH;
        end
      end
      S_FETCH: begin
        st_nxt.state = S_EXEC;
      end
      S_EXEC: begin
        st_nxt.dmem.wdata = dmem_rdata;
        case (st_r.req.op)
          OP_ROTATE_RIGHT_CARRY_TO_ACC: begin
            st_nxt.acc = {st_r.flags.carry, dmem_rdata[7:1]};
            st_nxt.flags.carry = dmem_rdata[0];
          end
          OP_SUBTRACT_WITH_BORROW, OP_SUBTRACT, OP_SUBTRACT_IMMEDIATE: begin
            st_nxt.acc = sum_full[7:0];
            st_nxt.flags = sub_flags;
          end
          OP_SUBTRACT_BORROW_TO_MEMORY, OP_SUBTRACT_TO_MEMORY: begin
            st_nxt.dmem.wr = 1'b1;
            st_nxt.dmem.wdata = sum_full[7:0];
            st_nxt.flags = sub_flags;
          end
          OP_DECREMENT_SKIP_IF_ZERO: begin
            st_nxt.dmem.wr = 1'b1;
            st_nxt.dmem.wdata = dec_val;
          end
          OP_DECREMENT_TO_ACC_SKIP_IF_ZERO: begin
            st_nxt.acc = dec_val;
          end
          OP_SET_BYTE: begin
            st_nxt.dmem.wr = 1'b1;
            st_nxt.dmem.wdata = ALL_ONES;
          end
          OP_SET_BIT: begin
            st_nxt.dmem.wr = 1'b1;
            st_nxt.dmem.wdata = dmem_rdata | bit_mask;
          end
          OP_INCREMENT_SKIP_IF_ZERO: begin
            st_nxt.dmem.wr = 1'b1;
            st_nxt.dmem.wdata = inc_val;
          end
          OP_INCREMENT_TO_ACC_SKIP_IF_ZERO: begin
            st_nxt.acc = inc_val;
          end
          OP_NIBBLE_EXCHANGE: begin
            st_nxt.dmem.wr = 1'b1;
            st_nxt.dmem.wdata = swp_val;
          end
          OP_NIBBLE_EXCHANGE_TO_ACC: begin
            st_nxt.acc = swp_val;
          end
          OP_MOVE_AND_SKIP_IF_ZERO: begin
            st_nxt.acc = dmem_rdata;
          end
          OP_TABLE_READ_CURRENT_PAGE, OP_TABLE_READ_LAST_PAGE: begin
            st_nxt.dmem.wr = 1'b1;
            st_nxt.dmem.wdata = pmem_rdata[7:0];
            st_nxt.table_high = pmem_rdata[14:8];
          end
          OP_EXCLUSIVE_OR, OP_EXCLUSIVE_OR_IMMEDIATE: begin
            st_nxt.acc = xor_val;
            st_nxt.flags.zero = (xor_val == 8'h00);
          end
          OP_EXCLUSIVE_OR_TO_MEMORY: begin
            st_nxt.dmem.wr = 1'b1;
            st_nxt.dmem.wdata = xor_val;
            st_nxt.flags.zero = (xor_val == 8'h00);
          end
          default: begin
          end
        endcase
        // a taken skip throws away the prefetch and spends a dummy cycle
        if (skip_op && skip_cond) begin
          st_nxt.skip = 1'b1;
          st_nxt.state = S_DUMMY;
        end else begin
          st_nxt.done = 1'b1;
          st_nxt.state = S_IDLE;
        end
      end
      S_DUMMY: begin
        st_nxt.done = 1'b1;
        st_nxt.state = S_IDLE;
      end
      default: begin
        st_nxt.state = S_IDLE;
      end
    endcase
    st_nxt.busy = (st_nxt.state != S_IDLE);
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      st_r.state <= S_IDLE;
      st_r.req <= '0;
      st_r.acc <= ACC_RST;
      st_r.flags <= mie_flags_t'(STATUS_RST);
      st_r.table_pointer <= TABLE_POINTER_RST;
      st_r.table_high <= TABLE_HIGH_RST;
      st_r.code_page <= CODE_PAGE_RST;
      st_r.dmem <= '0;
      st_r.pmem <= '0;
      st_r.rdata <= 8'h00;
      st_r.busy <= 1'b0;
      st_r.done <= 1'b0;
      st_r.skip <= 1'b0;
    end else if (ce) begin
      st_r <= st_nxt;
    end
  end

  assign reg_rdata = st_r.rdata;
  assign exec_busy = st_r.busy;
  assign exec_done = st_r.done;
  assign skip_next = st_r.skip;
  assign dmem_req = st_r.dmem;
  assign pmem_req = st_r.pmem;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  logic exec_go;
  assign exec_go = ce && (st_r.state == S_EXEC);

  rotate_acc_a: assert property (@(posedge core_clk) disable iff (!nrst)
    exec_go && st_r.req.op == OP_ROTATE_RIGHT_CARRY_TO_ACC |=>
      st_r.acc == {$past(st_r.flags.carry), $past(dmem_rdata[7:1])} &&
      st_r.flags.carry == $past(dmem_rdata[0]) && !st_r.dmem.wr)
    else $error("rotate through carry result wrong");

  borrow_sub_a: assert property (@(posedge core_clk) disable iff (!nrst)
    exec_go && st_r.req.op == OP_SUBTRACT_BORROW_TO_MEMORY |=>
      st_r.dmem.wr && st_r.dmem.wdata == $past(sum_full[7:0]) &&
      st_r.flags.carry == $past(sum_full[8]) && st_r.acc == $past(st_r.acc))
    else $error("subtract with borrow to memory wrong");

  dec_skip_a: assert property (@(posedge core_clk) disable iff (!nrst)
    exec_go && st_r.req.op == OP_DECREMENT_SKIP_IF_ZERO && dmem_rdata == 8'h01 |=>
      skip_next && !exec_done && st_r.dmem.wr && st_r.dmem.wdata == 8'h00 &&
      st_r.state == S_DUMMY)
    else $error("decrement skip not taken");

  set_byte_a: assert property (@(posedge core_clk) disable iff (!nrst)
    exec_go && st_r.req.op == OP_SET_BYTE |=>
      st_r.dmem.wdata == 8'hff && st_r.dmem.wr && $stable(st_r.flags))
    else $error("byte set wrong");

  set_bit_a: assert property (@(posedge core_clk) disable iff (!nrst)
    exec_go && st_r.req.op == OP_SET_BIT |=>
      st_r.dmem.wdata[$past(st_r.req.bit_sel)] &&
      (st_r.dmem.wdata & ~$past(bit_mask)) == ($past(dmem_rdata) & ~$past(bit_mask)))
    else $error("bit set touched other bits");

  inc_acc_a: assert property (@(posedge core_clk) disable iff (!nrst)
    exec_go && st_r.req.op == OP_INCREMENT_TO_ACC_SKIP_IF_ZERO |=>
      st_r.acc == $past(dmem_rdata) + 8'h01 && !st_r.dmem.wr &&
      skip_next == ($past(dmem_rdata) == 8'hff))
    else $error("increment to acc wrong");

  swap_mem_a: assert property (@(posedge core_clk) disable iff (!nrst)
    exec_go && st_r.req.op == OP_NIBBLE_EXCHANGE |=>
      st_r.dmem.wdata == {$past(dmem_rdata[3:0]), $past(dmem_rdata[7:4])} &&
      $stable(st_r.flags))
    else $error("nibble exchange wrong");

  last_page_a: assert property (@(posedge core_clk) disable iff (!nrst)
    ce && st_r.state == S_IDLE && issue_valid &&
    issue_req.op == OP_TABLE_READ_LAST_PAGE |=>
      pmem_req.rd && pmem_req.addr == {LAST_PAGE, $past(st_r.table_pointer)})
    else $error("last page table address wrong");

  xor_mem_a: assert property (@(posedge core_clk) disable iff (!nrst)
    exec_go && st_r.req.op == OP_EXCLUSIVE_OR_TO_MEMORY |=>
      st_r.dmem.wdata == ($past(st_r.acc) ^ $past(dmem_rdata)) &&
      st_r.flags.zero == ($past(st_r.acc) == $past(dmem_rdata)))
    else $error("xor to memory wrong");

  no_skip_a: assert property (@(posedge core_clk) disable iff (!nrst)
    exec_go && skip_op && !skip_cond |=> exec_done && !skip_next && !exec_busy)
    else $error("untaken skip did not finish in one cycle");

  skip_taken_c: cover property (@(posedge core_clk) disable iff (!nrst)
    skip_next ##1 exec_done);
  table_read_c: cover property (@(posedge core_clk) disable iff (!nrst)
    exec_go && st_r.req.op == OP_TABLE_READ_CURRENT_PAGE);
  sub_overflow_c: cover property (@(posedge core_clk) disable iff (!nrst)
    exec_go && st_r.req.op == OP_SUBTRACT_IMMEDIATE && sub_flags.signed_range);

endmodule : mie_exec

`default_nettype wire

// ===== rtl/mie_pkg.sv
// Purpose: shared constants and types of the instruction execution tail
// Assumes: 8-bit data path, 15-bit program words, 12-bit program addresses
// Notes: register offsets sit on the plain register port, one byte each
`default_nettype none

package mie_pkg;

  // ----------------------------------------------------------------
  // widths
  // ----------------------------------------------------------------
  localparam int DW = 8;
  localparam int PW = 15;
  localparam int PAW = 12;
  localparam int RAW = 4;

  // ----------------------------------------------------------------
  // register offsets
  // ----------------------------------------------------------------
  localparam logic [RAW-1:0] REG_ACC = 4'h0;
  localparam logic [RAW-1:0] REG_STATUS = 4'h1;
  localparam logic [RAW-1:0] REG_TABLE_POINTER = 4'h2;
  localparam logic [RAW-1:0] REG_TABLE_HIGH = 4'h3;
  localparam logic [RAW-1:0] REG_CODE_PAGE = 4'h4;
  localparam logic [RAW-1:0] REG_EXEC_STATE = 4'h5;

  // ----------------------------------------------------------------
  // field positions and reset values
  // ----------------------------------------------------------------
  localparam int CARRY_POS = 0;
  localparam int HALF_CARRY_POS = 1;
  localparam int ZERO_POS = 2;
  localparam int SIGNED_RANGE_POS = 3;
  localparam int BUSY_POS = 0;
  localparam logic [DW-1:0] ACC_RST = 8'h00;
  localparam logic [3:0] STATUS_RST = 4'h0;
  localparam logic [DW-1:0] TABLE_POINTER_RST = 8'h00;
  localparam logic [6:0] TABLE_HIGH_RST = 7'h00;
  localparam logic [3:0] CODE_PAGE_RST = 4'h0;
  localparam logic [3:0] LAST_PAGE = 4'hf;
  localparam logic [DW-1:0] ALL_ONES = 8'hff;

  // ----------------------------------------------------------------
  // timing: cycles spent on the discarded instruction
  // ----------------------------------------------------------------
  localparam int DUMMY_CYCLES = 1;

  typedef enum logic [4:0] {
    OP_ROTATE_RIGHT_CARRY_TO_ACC = 5'h00, OP_SUBTRACT_WITH_BORROW = 5'h01,
    OP_SUBTRACT_BORROW_TO_MEMORY = 5'h02, OP_SUBTRACT = 5'h03,
    OP_SUBTRACT_TO_MEMORY = 5'h04, OP_SUBTRACT_IMMEDIATE = 5'h05,
    OP_DECREMENT_SKIP_IF_ZERO = 5'h06, OP_DECREMENT_TO_ACC_SKIP_IF_ZERO = 5'h07,
    OP_SET_BYTE = 5'h08, OP_SET_BIT = 5'h09,
    OP_INCREMENT_SKIP_IF_ZERO = 5'h0a, OP_INCREMENT_TO_ACC_SKIP_IF_ZERO = 5'h0b,
    OP_SKIP_IF_BIT_SET = 5'h0c, OP_SKIP_IF_BIT_CLEAR = 5'h0d,
    OP_NIBBLE_EXCHANGE = 5'h0e, OP_NIBBLE_EXCHANGE_TO_ACC = 5'h0f,
    OP_SKIP_IF_ZERO = 5'h10, OP_MOVE_AND_SKIP_IF_ZERO = 5'h11,
    OP_TABLE_READ_CURRENT_PAGE = 5'h12, OP_TABLE_READ_LAST_PAGE = 5'h13,
    OP_EXCLUSIVE_OR = 5'h14, OP_EXCLUSIVE_OR_IMMEDIATE = 5'h15,
    OP_EXCLUSIVE_OR_TO_MEMORY = 5'h16
  } mie_op_t;

  typedef enum logic [3:0] {
    S_IDLE = 4'b0001, S_FETCH = 4'b0010, S_EXEC = 4'b0100, S_DUMMY = 4'b1000
  } mie_state_t;

  typedef struct packed {
    mie_op_t op;
    logic [DW-1:0] addr;
    logic [2:0] bit_sel;
    logic [DW-1:0] imm;
  } mie_req_t;

  typedef struct packed {
    logic signed_range;
    logic zero;
    logic half_carry;
    logic carry;
  } mie_flags_t;

  typedef struct packed {
    logic rd;
    logic wr;
    logic [DW-1:0] addr;
    logic [DW-1:0] wdata;
  } mie_dmem_t;

  typedef struct packed {
    logic rd;
    logic [PAW-1:0] addr;
  } mie_pmem_t;

endpackage : mie_pkg

`default_nettype wire

// ===== sim/mie_mem_model.sv
// Purpose: data and program memory facing the execution tail
// Assumes: every read strobe is answered in the following cycle
// Notes: idle read data is inverted every cycle, so stale data never passes for an answer
`default_nettype none

module mie_mem_model
  import mie_pkg::*;
(
  // clock
  input wire logic core_clk,
  // data memory
  input wire mie_dmem_t dmem_req,
  output logic [DW-1:0] dmem_rdata,
  // program memory
  input wire mie_pmem_t pmem_req,
  output logic [PW-1:0] pmem_rdata
);
  timeunit 1ns;
  timeprecision 1ns;

  logic [DW-1:0] ram [256];
  logic [PW-1:0] word;

  // program words are a fixed pattern of the address, so no file is needed
  assign word = {pmem_req.addr[11:5] ^ 7'h5a, pmem_req.addr[7:0] ^ 8'hc3};

  initial begin
    dmem_rdata = 8'h00;
    pmem_rdata = 15'h0000;
  end

  always @(posedge core_clk) begin
    if (dmem_req.wr) begin
      ram[dmem_req.addr] <= dmem_req.wdata;
    end
    dmem_rdata <= dmem_req.rd ? ram[dmem_req.addr] : ~dmem_rdata;
    pmem_rdata <= pmem_req.rd ? word : ~pmem_rdata;
  end
endmodule : mie_mem_model

`default_nettype wire

// ===== sim/tb_mcu_instruction_exec_tail.sv
// Purpose: self-checking bench for the instruction execution tail
// Assumes: the memory model answers reads one cycle later
// Notes: each case preloads memory and registers, runs one op, then compares skip, cycle count, busy, acc, status, memory and table high
`default_nettype none

module tb_mcu_instruction_exec_tail
  import mie_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;

  logic core_clk, nrst, ce, reg_wr, reg_rd, issue_valid, exec_busy, exec_done, skip_next;
  logic [RAW-1:0] reg_addr;
  logic [DW-1:0] reg_wdata, reg_rdata, dmem_rdata, rd_v, th_e;
  logic [PW-1:0] pmem_rdata;
  mie_req_t issue_req;
  mie_dmem_t dmem_req;
  mie_pmem_t pmem_req;
  int err_count, checks;

  mie_exec mie_exec_inst (.core_clk(core_clk), .nrst(nrst), .ce(ce), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .issue_valid(issue_valid), .issue_req(issue_req), .exec_busy(exec_busy),
    .exec_done(exec_done), .skip_next(skip_next), .dmem_req(dmem_req),
    .dmem_rdata(dmem_rdata), .pmem_req(pmem_req), .pmem_rdata(pmem_rdata));
  mie_mem_model mie_mem_model_inst (.core_clk(core_clk), .dmem_req(dmem_req),
    .dmem_rdata(dmem_rdata), .pmem_req(pmem_req), .pmem_rdata(pmem_rdata));

  initial begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end

  // a run is about 570 cycles; ten thousand means a hang
  initial begin
    #400000;
    err_count++;
    report_and_stop();
  end

  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic check(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      err_count++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checks, err_count);
    if (err_count == 0 && checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : report_and_stop

  task automatic reg_write(input logic [3:0] a, input logic [7:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask : reg_write

  task automatic reg_read(input logic [3:0] a);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 rd_v = reg_rdata;
  endtask : reg_read

  task automatic do_op(input mie_op_t op, input logic [7:0] m, a0, input logic [3:0] s0,
                       input logic [2:0] b, input logic [7:0] imm);
    logic [7:0] ea, em, opd, ad, x, s8;
    logic [3:0] es, fl;
    logic [8:0] s9;
    logic [4:0] s5;
    logic [14:0] w;
    logic cin, esk, sk;
    int n;
    ad = 8'h40 + {3'h0, op};
    mie_mem_model_inst.ram[ad] = m;
    reg_write(REG_ACC, a0);
    reg_write(REG_STATUS, {4'h0, s0});
    reg_write(REG_TABLE_POINTER, m);
    opd = (op == OP_SUBTRACT_IMMEDIATE || op == OP_EXCLUSIVE_OR_IMMEDIATE) ? imm : m;
    cin = (op == OP_SUBTRACT_WITH_BORROW || op == OP_SUBTRACT_BORROW_TO_MEMORY) ? s0[0] : 1'b1;
    s9 = {1'b0, a0} + {1'b0, ~opd} + 9'(cin);
    s5 = {1'b0, a0[3:0]} + {1'b0, ~opd[3:0]} + 5'(cin);
    s8 = {1'b0, a0[6:0]} + {1'b0, ~opd[6:0]} + 8'(cin);
    fl = {s8[7] ^ s9[8], s9[7:0] == 8'h00, s5[4], s9[8]};
    x = a0 ^ opd;
    w = (op == OP_TABLE_READ_LAST_PAGE) ? {LAST_PAGE, m} : {4'h3, m};
    w = {w[11:5] ^ 7'h5a, w[7:0] ^ 8'hc3};
    ea = a0;
    em = m;
    es = s0;
    esk = 1'b0;
    case (op)
      OP_ROTATE_RIGHT_CARRY_TO_ACC: {ea, es[0]} = {s0[0], m};
      OP_SUBTRACT_WITH_BORROW, OP_SUBTRACT,
      OP_SUBTRACT_IMMEDIATE: {ea, es} = {s9[7:0], fl};
      OP_SUBTRACT_BORROW_TO_MEMORY, OP_SUBTRACT_TO_MEMORY: {em, es} = {s9[7:0], fl};
      OP_DECREMENT_SKIP_IF_ZERO: {em, esk} = {m - 8'h01, m == 8'h01};
      OP_DECREMENT_TO_ACC_SKIP_IF_ZERO: {ea, esk} = {m - 8'h01, m == 8'h01};
      OP_SET_BYTE: em = ALL_ONES;
      OP_SET_BIT: em = m | (8'h01 << b);
      OP_INCREMENT_SKIP_IF_ZERO: {em, esk} = {m + 8'h01, m == 8'hff};
      OP_INCREMENT_TO_ACC_SKIP_IF_ZERO: {ea, esk} = {m + 8'h01, m == 8'hff};
      OP_SKIP_IF_BIT_SET: esk = m[b];
      OP_SKIP_IF_BIT_CLEAR: esk = !m[b];
      OP_NIBBLE_EXCHANGE: em = {m[3:0], m[7:4]};
      OP_NIBBLE_EXCHANGE_TO_ACC: ea = {m[3:0], m[7:4]};
      OP_SKIP_IF_ZERO: esk = (m == 8'h00);
      OP_MOVE_AND_SKIP_IF_ZERO: {ea, esk} = {m, m == 8'h00};
      OP_TABLE_READ_CURRENT_PAGE, OP_TABLE_READ_LAST_PAGE: {em, th_e} = {w[7:0], 1'b0, w[14:8]};
      OP_EXCLUSIVE_OR, OP_EXCLUSIVE_OR_IMMEDIATE: {ea, es[2]} = {x, x == 8'h00};
      OP_EXCLUSIVE_OR_TO_MEMORY: {em, es[2]} = {x, x == 8'h00};
      default: ;
    endcase
    // issue is held one edge into busy, where it must be ignored
    @(posedge core_clk);
    issue_req <= '{op: op, addr: ad, bit_sel: b, imm: imm};
    issue_valid <= 1'b1;
    sk = 1'b0;
    n = 0;
    while (n < 8 && exec_done !== 1'b1) begin
      @(posedge core_clk);
      n++;
      if (n == 2) issue_valid <= 1'b0;
      #1;
      if (skip_next === 1'b1) sk = 1'b1;
    end
    check("skip", {7'h0, sk}, {7'h0, esk});
    check("cycles", 8'(n), esk ? 8'h04 : 8'h03);
    @(posedge core_clk);
    #1 check("busy", {7'h0, exec_busy}, 8'h00);
    reg_read(REG_ACC);
    check("acc", rd_v, ea);
    reg_read(REG_STATUS);
    check("status", rd_v, {4'h0, es});
    check("mem", mie_mem_model_inst.ram[ad], em);
    reg_read(REG_TABLE_HIGH);
    check("table_high", rd_v, th_e);
  endtask : do_op

  // ----------------------------------------------------------------
  // sequence
  // ----------------------------------------------------------------
  initial begin
    nrst = 1'b0;
    ce = 1'b1;
    reg_addr = 4'h0;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    issue_valid = 1'b0;
    issue_req = '0;
    err_count = 0;
    checks = 0;
    th_e = 8'h00;
    repeat (6) @(posedge core_clk);
    nrst <= 1'b1;
    // read-only offsets must ignore writes; offset 9 is unmapped
    reg_write(REG_TABLE_HIGH, 8'h7f);
    reg_write(REG_EXEC_STATE, 8'h01);
    for (int i = 0; i < 7; i++) begin
      reg_read(i == 6 ? 4'h9 : 4'(i));
      check("reset", rd_v, 8'h00);
    end
    reg_write(REG_CODE_PAGE, 8'h03);
    do_op(OP_ROTATE_RIGHT_CARRY_TO_ACC, 8'h35, 8'h00, 4'h0, 3'h0, 8'h00);
    do_op(OP_SUBTRACT_WITH_BORROW, 8'h01, 8'h10, 4'h0, 3'h0, 8'h00);
    do_op(OP_SUBTRACT_BORROW_TO_MEMORY, 8'h01, 8'h80, 4'h1, 3'h0, 8'h00);
    do_op(OP_SUBTRACT, 8'h05, 8'h05, 4'h0, 3'h0, 8'h00);
    do_op(OP_SUBTRACT_TO_MEMORY, 8'h01, 8'h00, 4'hf, 3'h0, 8'h00);
    do_op(OP_SUBTRACT_IMMEDIATE, 8'h5a, 8'h7f, 4'h0, 3'h0, 8'hff);
    do_op(OP_DECREMENT_SKIP_IF_ZERO, 8'h01, 8'h00, 4'h0, 3'h0, 8'h00);
    do_op(OP_DECREMENT_SKIP_IF_ZERO, 8'h00, 8'h00, 4'h0, 3'h0, 8'h00);
    do_op(OP_DECREMENT_TO_ACC_SKIP_IF_ZERO, 8'h01, 8'h33, 4'h5, 3'h0, 8'h00);
    do_op(OP_DECREMENT_TO_ACC_SKIP_IF_ZERO, 8'h80, 8'h33, 4'h0, 3'h0, 8'h00);
    do_op(OP_SET_BYTE, 8'h12, 8'h00, 4'ha, 3'h0, 8'h00);
    do_op(OP_SET_BIT, 8'ha4, 8'h00, 4'h5, 3'h3, 8'h00);
    do_op(OP_INCREMENT_SKIP_IF_ZERO, 8'hff, 8'h00, 4'h0, 3'h0, 8'h00);
    do_op(OP_INCREMENT_SKIP_IF_ZERO, 8'h7f, 8'h00, 4'h0, 3'h0, 8'h00);
    do_op(OP_INCREMENT_TO_ACC_SKIP_IF_ZERO, 8'hff, 8'h11, 4'h3, 3'h0, 8'h00);
    do_op(OP_INCREMENT_TO_ACC_SKIP_IF_ZERO, 8'h00, 8'h11, 4'h0, 3'h0, 8'h00);
    do_op(OP_SKIP_IF_BIT_SET, 8'h80, 8'h00, 4'h0, 3'h7, 8'h00);
    do_op(OP_SKIP_IF_BIT_SET, 8'h80, 8'h00, 4'h0, 3'h6, 8'h00);
    do_op(OP_SKIP_IF_BIT_CLEAR, 8'hfb, 8'h00, 4'h0, 3'h2, 8'h00);
    do_op(OP_SKIP_IF_BIT_CLEAR, 8'hfb, 8'h00, 4'h0, 3'h1, 8'h00);
    do_op(OP_NIBBLE_EXCHANGE, 8'ha5, 8'h00, 4'hf, 3'h0, 8'h00);
    do_op(OP_NIBBLE_EXCHANGE_TO_ACC, 8'h3c, 8'h00, 4'hf, 3'h0, 8'h00);
    do_op(OP_SKIP_IF_ZERO, 8'h00, 8'h00, 4'h0, 3'h0, 8'h00);
    do_op(OP_SKIP_IF_ZERO, 8'h01, 8'h00, 4'h0, 3'h0, 8'h00);
    do_op(OP_MOVE_AND_SKIP_IF_ZERO, 8'h00, 8'h77, 4'h0, 3'h0, 8'h00);
    do_op(OP_MOVE_AND_SKIP_IF_ZERO, 8'h40, 8'h77, 4'h0, 3'h0, 8'h00);
    do_op(OP_TABLE_READ_CURRENT_PAGE, 8'h21, 8'h00, 4'h0, 3'h0, 8'h00);
    do_op(OP_TABLE_READ_LAST_PAGE, 8'hfe, 8'h00, 4'h0, 3'h0, 8'h00);
    do_op(OP_EXCLUSIVE_OR, 8'h3c, 8'h3c, 4'hb, 3'h0, 8'h00);
    do_op(OP_EXCLUSIVE_OR_IMMEDIATE, 8'h00, 8'hf0, 4'hf, 3'h0, 8'h0f);
    do_op(OP_EXCLUSIVE_OR_TO_MEMORY, 8'haa, 8'h55, 4'h4, 3'h0, 8'h00);
    // a write while the enable is low must leave the accumulator alone
    @(posedge core_clk);
    ce <= 1'b0;
    reg_write(REG_ACC, 8'haa);
    ce <= 1'b1;
    reg_read(REG_ACC);
    check("freeze", rd_v, 8'h55);
    report_and_stop();
  end
endmodule : tb_mcu_instruction_exec_tail

`default_nettype wire
